// ### include/exec_pkg.sv
// Shared types and constants for the ALU and branch executor
package exec_pkg;
   localparam int REG_COUNT = 32;
   localparam int PC_W = 16;
   typedef logic [PC_W-1:0] pc_t;
   localparam logic [4:0] ZPTR_LO = 5'h1E;
   localparam logic [4:0] ZPTR_HI = 5'h1F;
   localparam pc_t PC_RESET = 16'h0000;
   localparam logic [7:0] SREG_RESET = 8'h00;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   // Status bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_I = 7;
   // Cycle counts per instruction
   localparam logic [2:0] CYC_SINGLE = 3'h1;
   localparam logic [2:0] CYC_WORD = 3'h2;
   localparam logic [2:0] CYC_REL_JUMP = 3'h2;
   localparam logic [2:0] CYC_IND_JUMP = 3'h2;
   localparam logic [2:0] CYC_ABS_JUMP = 3'h3;
   localparam logic [2:0] CYC_REL_INVOKE = 3'h3;
   localparam logic [2:0] CYC_IND_INVOKE = 3'h3;
   localparam logic [2:0] CYC_ABS_INVOKE = 3'h4;
   localparam logic [2:0] CYC_RETURN = 3'h4;
   localparam logic [2:0] CYC_SKIP_SHORT = 3'h2;
   localparam logic [2:0] CYC_SKIP_LONG = 3'h3;
   // Program counter steps
   localparam pc_t PC_STEP = 16'h0001;
   localparam pc_t PC_SKIP_SHORT = 16'h0002;
   localparam pc_t PC_SKIP_LONG = 16'h0003;
   localparam pc_t ABS_RETURN_STEP = 16'h0002;

   typedef enum logic [3:0] {
      ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR,
      ALU_INVERT, ALU_NEGATE, ALU_INC, ALU_DEC, ALU_PASS
   } alu_op_t;

   typedef enum logic [5:0] {
      OP_ADD, OP_ADD_CARRY, OP_WORD_ADD_IMMEDIATE, OP_SUB, OP_SUBTRACT_IMMEDIATE,
      OP_SUBTRACT_WITH_CARRY, OP_SUBTRACT_CARRY_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE,
      OP_AND, OP_AND_IMMEDIATE, OP_OR, OP_OR_IMMEDIATE, OP_EXCLUSIVE_OR,
      OP_BITWISE_INVERT, OP_ARITHMETIC_INVERT, OP_SET_BITS_IMMEDIATE,
      OP_CLEAR_BITS_IMMEDIATE, OP_INC, OP_DEC, OP_ZERO_SIGN_TEST, OP_CLEAR,
      OP_SET_ALL_ONES, OP_RELATIVE_JUMP, OP_INDIRECT_JUMP, OP_ABSOLUTE_JUMP,
      OP_RELATIVE_INVOKE, OP_INDIRECT_INVOKE, OP_ABSOLUTE_INVOKE,
      OP_POP_RETURN_TARGET, OP_INTERRUPT_EXIT, OP_COMPARE_SKIP_EQUAL,
      OP_REGISTER_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE
   } op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_BUSY = 2'h2
   } state_t;

   typedef struct packed {
      logic h;
      logic v;
      logic n;
      logic z;
      logic c;
   } flags_t;

   localparam flags_t MASK_NONE = 5'h00;
   localparam flags_t MASK_ARITH = 5'h1F;
   localparam flags_t MASK_LOGIC = 5'h0E;
   localparam flags_t MASK_INVERT = 5'h0F;

   typedef struct packed {
      op_t op;
      logic [4:0] rd;
      logic [4:0] rr;
      logic [7:0] imm;
      logic [11:0] offset;
      pc_t target;
   } cmd_t;

   typedef struct packed {
      logic valid;
      pc_t addr;
   } stack_push_t;
endpackage

// ### rtl/exec_alu.sv
// Eight-bit arithmetic and logic unit with flag results
`timescale 1ns/1ps
module exec_alu
   import exec_pkg::*;
(
   // Operands
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cin,
   input wire logic zin,
   input wire alu_op_t op,
   // Result
   output logic [7:0] res,
   output flags_t flg
);
   logic [8:0] wide;

   always_comb
   begin
      wide = {1'b0, a};
      case (op)
         ALU_ADD: wide = {1'b0, a} + {1'b0, b} + {8'h00, cin};
         ALU_SUB: wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
         ALU_AND: wide = {1'b0, a & b};
         ALU_OR: wide = {1'b0, a | b};
         ALU_XOR: wide = {1'b0, a ^ b};
         ALU_INVERT: wide = {1'b1, ALL_ONES - a};
         ALU_NEGATE: wide = 9'h000 - {1'b0, a};
         ALU_INC: wide = {1'b0, a + 8'h01};
         ALU_DEC: wide = {1'b0, a - 8'h01};
         default: wide = {1'b0, a};
      endcase
      res = wide[7:0];
      flg.c = wide[8];
      flg.n = res[7];
      flg.z = (res == 8'h00) & zin;
      flg.h = 1'b0;
      flg.v = 1'b0;
      case (op)
         ALU_ADD:
         begin
            flg.h = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
            flg.v = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
         end
         ALU_SUB:
         begin
            flg.h = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
            flg.v = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
         end
         ALU_NEGATE:
         begin
            flg.h = res[3] | a[3];
            flg.v = (res == 8'h80);
         end
         ALU_INC: flg.v = (res == 8'h80);
         ALU_DEC: flg.v = (res == 8'h7F);
         default: flg.v = 1'b0;
      endcase
   end
endmodule

// ### rtl/exec_core.sv
// Executor for arithmetic, logic and branch instructions
//
// Notes on behaviour
// - Add, optional carry; ZCNVH; one cycle
// - Word add immediate on pair; ZCNVS; two cycles
// - Subtract registers into destination; ZCNVH; one cycle
// - Subtract constant from register; ZCNVH; one cycle
// - Subtract with carry, both forms; one cycle
// - Word subtract immediate on pair; two cycles
// - AND and OR keep carry, half-carry
// - Exclusive or; updates Z N V only
// - Set bits: OR constant mask in
// - Clear bits: AND with inverted mask
// - Test: AND register with itself, ZNV
// - Indirect jump loads pc from pointer; two cycles
// - Relative invoke pushes, pc plus offset plus one
// - Absolute invoke pushes, loads target; four cycles
// - Indirect invoke pushes, loads pointer; three cycles
// - Compare skip equal steps pc two or three on a match, one otherwise
// - Compare immediate sets flags, no write back
`timescale 1ns/1ps
module exec_core
   import exec_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Instruction command
   input wire logic cmd_valid,
   input wire cmd_t cmd,
   output logic cmd_ready,
   input wire logic next_two_word,
   output logic done,
   // Stack
   output stack_push_t push,
   output logic pop_req,
   input wire pc_t pop_data,
   // State
   output pc_t pc,
   output logic [7:0] sreg,
   input wire logic [4:0] dbg_addr,
   output logic [7:0] dbg_data
);
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Declarations
   state_t state_q, state_d;
   logic [2:0] cnt_q, cnt_d;
   pc_t pc_q, pc_d;
   logic [7:0] sreg_q, sreg_d;
   logic [7:0] wlo_q, wlo_d;
   logic wcy_q, wcy_d;
   logic wsub_q, wsub_d;
   logic word_q, word_d;
   logic [4:0] waddr_q, waddr_d;
   logic done_q, done_d;
   stack_push_t push_q, push_d;
   logic [7:0] dbg_q, dbg_d;
   logic accept;
   logic [7:0] rd_val, rr_val, dbg_val;
   pc_t zptr, off_ext;
   logic rf_we;
   logic [4:0] rf_waddr, raddr_a;
   logic [7:0] rf_wdata;
   alu_op_t aop;
   logic [7:0] bsel;
   logic cin, zin, wen, push_en, pop_en, word_op, set_i;
   flags_t fmask, aflg;
   logic [7:0] ares;
   logic [2:0] cyc;
   pc_t pc_tgt, push_addr;
   logic [7:0] hi_res;
   logic [15:0] wres;
   logic [7:0] word_flags;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Datapath
   assign cmd_ready = (state_q == ST_IDLE);
   assign accept = cmd_valid & cmd_ready;
   assign off_ext = {{4{cmd.offset[11]}}, cmd.offset};
   assign raddr_a = (state_q == ST_BUSY) ? waddr_q : cmd.rd;

   exec_regfile u_regs (
      .mclk(mclk),
      .nrst(nrst),
      .we(rf_we),
      .waddr(rf_waddr),
      .wdata(rf_wdata),
      .raddr_a(raddr_a),
      .raddr_b(cmd.rr),
      .raddr_c(dbg_addr),
      .rdata_a(rd_val),
      .rdata_b(rr_val),
      .rdata_c(dbg_val),
      .zptr(zptr)
   );

   exec_alu u_alu (
      .a(rd_val),
      .b(bsel),
      .cin(cin),
      .zin(zin),
      .op(aop),
      .res(ares),
      .flg(aflg)
   );

   // Second half of word operations on the high byte
   always_comb
   begin
      hi_res = wsub_q ? rd_val - {7'h00, wcy_q} : rd_val + {7'h00, wcy_q};
      wres = {hi_res, wlo_q};
      word_flags = sreg_q;
      word_flags[FLAG_Z] = (wres == 16'h0000);
      word_flags[FLAG_N] = wres[15];
      word_flags[FLAG_V] = wsub_q ? (rd_val[7] & ~wres[15]) : (~rd_val[7] & wres[15]);
      word_flags[FLAG_C] = wsub_q ? (wres[15] & ~rd_val[7]) : (~wres[15] & rd_val[7]);
      word_flags[FLAG_S] = word_flags[FLAG_N] ^ word_flags[FLAG_V];
   end

   always_comb
   begin
      rf_we = (accept & wen) | ((state_q == ST_BUSY) & word_q);
      rf_waddr = (state_q == ST_BUSY) ? waddr_q : cmd.rd;
      rf_wdata = (state_q == ST_BUSY) ? hi_res : ares;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Instruction decode
   always_comb
   begin
      aop = ALU_PASS;
      bsel = rr_val;
      cin = 1'b0;
      zin = 1'b1;
      wen = 1'b0;
      fmask = MASK_NONE;
      cyc = CYC_SINGLE;
      pc_tgt = pc_q + PC_STEP;
      push_en = 1'b0;
      push_addr = pc_q + PC_STEP;
      pop_en = 1'b0;
      word_op = 1'b0;
      set_i = 1'b0;
      case (cmd.op)
         OP_ADD, OP_ADD_CARRY:
         begin
            aop = ALU_ADD;
            cin = (cmd.op == OP_ADD_CARRY) & sreg_q[FLAG_C];
            wen = 1'b1;
            fmask = MASK_ARITH;
         end
         OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE:
         begin
            aop = (cmd.op == OP_WORD_ADD_IMMEDIATE) ? ALU_ADD : ALU_SUB;
            bsel = cmd.imm;
            wen = 1'b1;
            word_op = 1'b1;
            cyc = CYC_WORD;
         end
         OP_SUB, OP_SUBTRACT_IMMEDIATE:
         begin
            aop = ALU_SUB;
            bsel = (cmd.op == OP_SUB) ? rr_val : cmd.imm;
            wen = 1'b1;
            fmask = MASK_ARITH;
         end
         OP_SUBTRACT_WITH_CARRY, OP_SUBTRACT_CARRY_IMMEDIATE:
         begin
            aop = ALU_SUB;
            bsel = (cmd.op == OP_SUBTRACT_WITH_CARRY) ? rr_val : cmd.imm;
            cin = sreg_q[FLAG_C];
            zin = sreg_q[FLAG_Z];
            wen = 1'b1;
            fmask = MASK_ARITH;
         end
         OP_AND, OP_AND_IMMEDIATE, OP_OR, OP_OR_IMMEDIATE:
         begin
            aop = (cmd.op == OP_AND || cmd.op == OP_AND_IMMEDIATE) ? ALU_AND : ALU_OR;
            bsel = (cmd.op == OP_AND || cmd.op == OP_OR) ? rr_val : cmd.imm;
            wen = 1'b1;
            fmask = MASK_LOGIC;
         end
         OP_EXCLUSIVE_OR, OP_CLEAR:
         begin
            aop = ALU_XOR;
            bsel = (cmd.op == OP_CLEAR) ? rd_val : rr_val;
            wen = 1'b1;
            fmask = MASK_LOGIC;
         end
         OP_SET_BITS_IMMEDIATE:
         begin
            aop = ALU_OR;
            bsel = cmd.imm;
            wen = 1'b1;
            fmask = MASK_LOGIC;
         end
         OP_CLEAR_BITS_IMMEDIATE:
         begin
            aop = ALU_AND;
            bsel = ALL_ONES - cmd.imm;
            wen = 1'b1;
            fmask = MASK_LOGIC;
         end
         OP_ZERO_SIGN_TEST:
         begin
            aop = ALU_AND;
            bsel = rd_val;
            wen = 1'b1;
            fmask = MASK_LOGIC;
         end
         OP_BITWISE_INVERT:
         begin
            aop = ALU_INVERT;
            wen = 1'b1;
            fmask = MASK_INVERT;
         end
         OP_ARITHMETIC_INVERT:
         begin
            aop = ALU_NEGATE;
            wen = 1'b1;
            fmask = MASK_ARITH;
         end
         OP_INC, OP_DEC:
         begin
            aop = (cmd.op == OP_INC) ? ALU_INC : ALU_DEC;
            wen = 1'b1;
            fmask = MASK_LOGIC;
         end
         OP_SET_ALL_ONES:
         begin
            aop = ALU_OR;
            bsel = ALL_ONES;
            wen = 1'b1;
         end
         OP_RELATIVE_JUMP:
         begin
            pc_tgt = pc_q + off_ext + PC_STEP;
            cyc = CYC_REL_JUMP;
         end
         OP_INDIRECT_JUMP:
         begin
            pc_tgt = zptr;
            cyc = CYC_IND_JUMP;
         end
         OP_ABSOLUTE_JUMP:
         begin
            pc_tgt = cmd.target;
            cyc = CYC_ABS_JUMP;
         end
         OP_RELATIVE_INVOKE:
         begin
            pc_tgt = pc_q + off_ext + PC_STEP;
            push_en = 1'b1;
            cyc = CYC_REL_INVOKE;
         end
         OP_INDIRECT_INVOKE:
         begin
            pc_tgt = zptr;
            push_en = 1'b1;
            cyc = CYC_IND_INVOKE;
         end
         OP_ABSOLUTE_INVOKE:
         begin
            pc_tgt = cmd.target;
            push_addr = pc_q + ABS_RETURN_STEP;
            push_en = 1'b1;
            cyc = CYC_ABS_INVOKE;
         end
         OP_POP_RETURN_TARGET, OP_INTERRUPT_EXIT:
         begin
            pc_tgt = pop_data;
            pop_en = 1'b1;
            set_i = (cmd.op == OP_INTERRUPT_EXIT);
            cyc = CYC_RETURN;
         end
         OP_COMPARE_SKIP_EQUAL:
         begin
            if (rd_val == rr_val)
            begin
               pc_tgt = pc_q + (next_two_word ? PC_SKIP_LONG : PC_SKIP_SHORT);
               cyc = next_two_word ? CYC_SKIP_LONG : CYC_SKIP_SHORT;
            end
         end
         OP_REGISTER_COMPARE, OP_COMPARE_WITH_CARRY:
         begin
            aop = ALU_SUB;
            cin = (cmd.op == OP_COMPARE_WITH_CARRY) & sreg_q[FLAG_C];
            zin = (cmd.op == OP_COMPARE_WITH_CARRY) ? sreg_q[FLAG_Z] : 1'b1;
            fmask = MASK_ARITH;
         end
         OP_COMPARE_IMMEDIATE:
         begin
            aop = ALU_SUB;
            bsel = cmd.imm;
            fmask = MASK_ARITH;
         end
         default: aop = ALU_PASS;
      endcase
   end

   assign pop_req = accept & pop_en;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      pc_d = pc_q;
      sreg_d = sreg_q;
      wlo_d = wlo_q;
      wcy_d = wcy_q;
      wsub_d = wsub_q;
      word_d = word_q;
      waddr_d = waddr_q;
      done_d = 1'b0;
      push_d = '0;
      dbg_d = dbg_val;
      case (state_q)
         ST_IDLE:
         begin
            if (accept)
            begin
               pc_d = pc_tgt;
               if (fmask.c) sreg_d[FLAG_C] = aflg.c;
               if (fmask.z) sreg_d[FLAG_Z] = aflg.z;
               if (fmask.n) sreg_d[FLAG_N] = aflg.n;
               if (fmask.v) sreg_d[FLAG_V] = aflg.v;
               if (fmask.h) sreg_d[FLAG_H] = aflg.h;
               if (set_i) sreg_d[FLAG_I] = 1'b1;
               push_d.valid = push_en;
               push_d.addr = push_addr;
               word_d = word_op;
               wlo_d = ares;
               wcy_d = aflg.c;
               wsub_d = (aop == ALU_SUB);
               waddr_d = cmd.rd + 5'h01;
               if (cyc == CYC_SINGLE)
                  done_d = 1'b1;
               else
               begin
                  state_d = ST_BUSY;
                  cnt_d = cyc - 3'h1;
               end
            end
         end
         ST_BUSY:
         begin
            cnt_d = cnt_q - 3'h1;
            if (word_q)
               sreg_d = word_flags;
            if (cnt_q == 3'h1)
            begin
               state_d = ST_IDLE;
               done_d = 1'b1;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= ST_IDLE;
         cnt_q <= 3'h0;
         pc_q <= PC_RESET;
         sreg_q <= SREG_RESET;
         wlo_q <= 8'h00;
         wcy_q <= 1'b0;
         wsub_q <= 1'b0;
         word_q <= 1'b0;
         waddr_q <= 5'h00;
         done_q <= 1'b0;
         push_q <= '0;
         dbg_q <= 8'h00;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         pc_q <= pc_d;
         sreg_q <= sreg_d;
         wlo_q <= wlo_d;
         wcy_q <= wcy_d;
         wsub_q <= wsub_d;
         word_q <= word_d;
         waddr_q <= waddr_d;
         done_q <= done_d;
         push_q <= push_d;
         dbg_q <= dbg_d;
      end
   end

   assign pc = pc_q;
   assign sreg = sreg_q;
   assign done = done_q;
   assign push = push_q;
   assign dbg_data = dbg_q;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking chk_cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   logic [8:0] chk_sum;
   assign chk_sum = {1'b0, rd_val} + {1'b0, rr_val};

   add_flags_a: assert property (
      accept && cmd.op == OP_ADD |=> done_q && sreg_q[FLAG_C] == $past(chk_sum[8])
         && sreg_q[FLAG_Z] == ($past(chk_sum[7:0]) == 8'h00))
      else $error("add flags wrong");
   word_add_a: assert property (
      accept && cmd.op == OP_WORD_ADD_IMMEDIATE |=> !cmd_ready && rf_we ##1 cmd_ready && done_q)
      else $error("word add timing wrong");
   sub_borrow_a: assert property (
      accept && cmd.op == OP_SUB |=> sreg_q[FLAG_C] == $past(rd_val < rr_val))
      else $error("subtract borrow wrong");
   sub_imm_a: assert property (
      accept && cmd.op == OP_SUBTRACT_IMMEDIATE |-> rf_we && rf_wdata == rd_val - cmd.imm)
      else $error("subtract immediate result wrong");
   sub_carry_a: assert property (
      accept && cmd.op == OP_SUBTRACT_WITH_CARRY
         |-> rf_wdata == rd_val - rr_val - {7'h00, sreg_q[FLAG_C]})
      else $error("subtract with carry wrong");
   word_sub_a: assert property (
      accept && cmd.op == OP_WORD_SUBTRACT_IMMEDIATE |=> !cmd_ready
         ##1 cmd_ready && sreg_q[FLAG_S] == (sreg_q[FLAG_N] ^ sreg_q[FLAG_V]))
      else $error("word subtract wrong");
   logic_keep_a: assert property (
      accept && (cmd.op == OP_AND || cmd.op == OP_OR_IMMEDIATE)
         |=> sreg_q[FLAG_C] == $past(sreg_q[FLAG_C]) && sreg_q[FLAG_H] == $past(sreg_q[FLAG_H]))
      else $error("logic op touched carry");
   xor_result_a: assert property (
      accept && cmd.op == OP_EXCLUSIVE_OR |-> rf_we && rf_wdata == (rd_val ^ rr_val))
      else $error("exclusive or wrong");
   clear_bits_a: assert property (
      accept && cmd.op == OP_CLEAR_BITS_IMMEDIATE |-> rf_wdata == (rd_val & ~cmd.imm))
      else $error("clear bits wrong");
   zero_test_a: assert property (
      accept && cmd.op == OP_ZERO_SIGN_TEST
         |=> sreg_q[FLAG_Z] == ($past(rd_val) == 8'h00) && !sreg_q[FLAG_V])
      else $error("zero test wrong");
   ind_jump_a: assert property (
      accept && cmd.op == OP_INDIRECT_JUMP |=> pc_q == $past(zptr) && !cmd_ready ##1 cmd_ready)
      else $error("indirect jump wrong");
   rel_invoke_a: assert property (
      accept && cmd.op == OP_RELATIVE_INVOKE |=> push_q.valid
         && push_q.addr == $past(pc_q) + PC_STEP ##0 !cmd_ready [*2] ##1 cmd_ready)
      else $error("relative invoke wrong");
   abs_invoke_a: assert property (
      accept && cmd.op == OP_ABSOLUTE_INVOKE
         |=> pc_q == $past(cmd.target) ##0 !cmd_ready [*3] ##1 cmd_ready)
      else $error("absolute invoke wrong");
   skip_long_a: assert property (
      accept && cmd.op == OP_COMPARE_SKIP_EQUAL && rd_val == rr_val && next_two_word
         |=> pc_q == $past(pc_q) + PC_SKIP_LONG ##0 !cmd_ready [*2] ##1 cmd_ready)
      else $error("skip step wrong");
   cmp_nowrite_a: assert property (
      accept && (cmd.op == OP_COMPARE_IMMEDIATE || cmd.op == OP_REGISTER_COMPARE) |-> !rf_we)
      else $error("compare wrote back");
   iexit_flag_a: assert property (
      accept && cmd.op == OP_INTERRUPT_EXIT
         |-> pop_req ##1 sreg_q[FLAG_I] ##0 !cmd_ready [*3] ##1 cmd_ready)
      else $error("interrupt exit wrong");
endmodule

// ### rtl/exec_regfile.sv
// Working register file of 32 bytes with three read ports
`timescale 1ns/1ps
module exec_regfile
   import exec_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Write port
   input wire logic we,
   input wire logic [4:0] waddr,
   input wire logic [7:0] wdata,
   // Read ports
   input wire logic [4:0] raddr_a,
   input wire logic [4:0] raddr_b,
   input wire logic [4:0] raddr_c,
   output logic [7:0] rdata_a,
   output logic [7:0] rdata_b,
   output logic [7:0] rdata_c,
   output pc_t zptr
);
   logic [7:0] mem_q [REG_COUNT];

   for (genvar i = 0; i < REG_COUNT; i++)
   begin : g_entry
      logic [7:0] ent_d;
      always_comb
      begin
         ent_d = mem_q[i];
         if (we && waddr == 5'(i))
            ent_d = wdata;
      end
      always_ff @(posedge mclk or negedge nrst)
      begin
         if (!nrst)
            mem_q[i] <= REG_RESET;
         else
            mem_q[i] <= ent_d;
      end
   end

   assign rdata_a = mem_q[raddr_a];
   assign rdata_b = mem_q[raddr_b];
   assign rdata_c = mem_q[raddr_c];
   assign zptr = {mem_q[ZPTR_HI], mem_q[ZPTR_LO]};
endmodule

// ### verification/alu_and_branch_execution_tb_top.sv
// Self-checking testbench for the ALU and branch executor
`timescale 1ns/1ps
module alu_and_branch_execution_tb_top
   import exec_pkg::*;
;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic cmd_valid = 1'b0;
   cmd_t cmd = '0;
   logic cmd_ready;
   logic next_two_word = 1'b0;
   logic done;
   stack_push_t push;
   logic pop_req;
   pc_t pop_data = 16'h0000;
   pc_t pc;
   logic [7:0] sreg;
   logic [4:0] dbg_addr = 5'h00;
   logic [7:0] dbg_data;
   pc_t epc = 16'h0000;
   pc_t lp = 16'h0000;
   logic pq = 1'b0;
   logic [7:0] esr = 8'h00;
   int num_errors = 0;
   int total_checks = 0;

   always #5 mclk = ~mclk;

   exec_core i_exec_core (.mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .next_two_word(next_two_word), .done(done), .push(push),
      .pop_req(pop_req), .pop_data(pop_data), .pc(pc), .sreg(sreg), .dbg_addr(dbg_addr),
      .dbg_data(dbg_data));

   // Last pushed return address and the stack pop seen at each edge
   always @(posedge mclk)
   begin
      pq <= pop_req;
      if (push.valid === 1'b1)
         lp <= push.addr;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", s, exp, seen);
      end
   endtask

   task test_done;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task go(input op_t o, input logic [4:0] d, input logic [4:0] r, input logic [7:0] k,
      input logic [2:0] n);
      int c;
      cmd.op = o;
      cmd.rd = d;
      cmd.rr = r;
      cmd.imm = k;
      cmd_valid = 1'b1;
      @(posedge mclk);
      #1 cmd_valid = 1'b0;
      chk("ready", {15'h0000, cmd_ready}, {15'h0000, n == 3'h1});
      chk("pop", {15'h0000, pq}, {15'h0000, o == OP_POP_RETURN_TARGET || o == OP_INTERRUPT_EXIT});
      c = 1;
      while (done !== 1'b1 && c < 10)
      begin
         @(posedge mclk);
         #1 c++;
      end
      chk("cycles", 16'(c), {13'h0000, n});
   endtask

   task rv(input logic [4:0] a, input logic [7:0] v);
      dbg_addr = a;
      @(posedge mclk);
      #1 chk("reg", {8'h00, dbg_data}, {8'h00, v});
   endtask

   task alu(input op_t o, input logic [4:0] d, input logic [4:0] r, input logic [7:0] k,
      input logic [2:0] n, input logic [7:0] v, input logic [7:0] s);
      go(o, d, r, k, n);
      epc = epc + 16'h0001;
      esr = s;
      chk("pc", pc, epc);
      chk("sreg", {8'h00, sreg}, {8'h00, s});
      rv(d, v);
   endtask

   task br(input op_t o, input logic [4:0] d, input logic [4:0] r, input logic [2:0] n,
      input pc_t p, input pc_t q);
      go(o, d, r, 8'h00, n);
      epc = p;
      chk("pc", pc, p);
      chk("push", lp, q);
      chk("sreg", {8'h00, sreg}, {8'h00, esr});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #20000;
      num_errors++;
      test_done;
   end

   initial
   begin
      repeat (10) @(posedge mclk);
      #1 nrst = 1'b1;
      alu(OP_SET_ALL_ONES, 5'h10, 5'h00, 8'h00, 3'h1, 8'hFF, 8'h00);
      alu(OP_INC, 5'h11, 5'h00, 8'h00, 3'h1, 8'h01, 8'h00);
      alu(OP_ADD, 5'h10, 5'h11, 8'h00, 3'h1, 8'h00, 8'h23);
      alu(OP_ADD_CARRY, 5'h11, 5'h11, 8'h00, 3'h1, 8'h03, 8'h00);
      alu(OP_SUB, 5'h12, 5'h11, 8'h00, 3'h1, 8'hFD, 8'h25);
      alu(OP_AND_IMMEDIATE, 5'h12, 5'h00, 8'h0F, 3'h1, 8'h0D, 8'h21);
      alu(OP_AND, 5'h12, 5'h12, 8'h00, 3'h1, 8'h0D, 8'h21);
      alu(OP_SUBTRACT_WITH_CARRY, 5'h11, 5'h10, 8'h00, 3'h1, 8'h02, 8'h00);
      alu(OP_SUBTRACT_IMMEDIATE, 5'h11, 5'h00, 8'h03, 3'h1, 8'hFF, 8'h25);
      alu(OP_SUBTRACT_CARRY_IMMEDIATE, 5'h11, 5'h00, 8'hFE, 3'h1, 8'h00, 8'h00);
      alu(OP_REGISTER_COMPARE, 5'h10, 5'h12, 8'h00, 3'h1, 8'h00, 8'h25);
      alu(OP_COMPARE_WITH_CARRY, 5'h12, 5'h10, 8'h00, 3'h1, 8'h0D, 8'h00);
      alu(OP_COMPARE_IMMEDIATE, 5'h12, 5'h00, 8'h0D, 3'h1, 8'h0D, 8'h02);
      alu(OP_OR, 5'h10, 5'h12, 8'h00, 3'h1, 8'h0D, 8'h00);
      alu(OP_OR_IMMEDIATE, 5'h10, 5'h00, 8'h80, 3'h1, 8'h8D, 8'h04);
      alu(OP_EXCLUSIVE_OR, 5'h10, 5'h12, 8'h00, 3'h1, 8'h80, 8'h04);
      alu(OP_SET_BITS_IMMEDIATE, 5'h10, 5'h00, 8'h01, 3'h1, 8'h81, 8'h04);
      alu(OP_CLEAR_BITS_IMMEDIATE, 5'h10, 5'h00, 8'h81, 3'h1, 8'h00, 8'h02);
      alu(OP_BITWISE_INVERT, 5'h10, 5'h00, 8'h00, 3'h1, 8'hFF, 8'h05);
      alu(OP_ZERO_SIGN_TEST, 5'h10, 5'h00, 8'h00, 3'h1, 8'hFF, 8'h05);
      alu(OP_ARITHMETIC_INVERT, 5'h10, 5'h00, 8'h00, 3'h1, 8'h01, 8'h21);
      alu(OP_DEC, 5'h10, 5'h00, 8'h00, 3'h1, 8'h00, 8'h23);
      alu(OP_CLEAR, 5'h12, 5'h00, 8'h00, 3'h1, 8'h00, 8'h23);
      alu(OP_WORD_SUBTRACT_IMMEDIATE, 5'h1A, 5'h00, 8'h01, 3'h2, 8'hFF, 8'h35);
      rv(5'h1B, 8'hFF);
      alu(OP_WORD_ADD_IMMEDIATE, 5'h1A, 5'h00, 8'h01, 3'h2, 8'h00, 8'h23);
      rv(5'h1B, 8'h00);
      alu(OP_SET_ALL_ONES, ZPTR_LO, 5'h00, 8'h00, 3'h1, 8'hFF, 8'h23);
      br(OP_INDIRECT_JUMP, 5'h00, 5'h00, 3'h2, 16'h00FF, 16'h0000);
      cmd.offset = 12'hFFE;
      br(OP_RELATIVE_JUMP, 5'h00, 5'h00, 3'h2, 16'h00FE, 16'h0000);
      cmd.target = 16'h1000;
      br(OP_ABSOLUTE_JUMP, 5'h00, 5'h00, 3'h3, 16'h1000, 16'h0000);
      cmd.offset = 12'h800;
      br(OP_RELATIVE_INVOKE, 5'h00, 5'h00, 3'h3, 16'h0801, 16'h1001);
      cmd.target = 16'h2468;
      br(OP_ABSOLUTE_INVOKE, 5'h00, 5'h00, 3'h4, 16'h2468, 16'h0803);
      br(OP_INDIRECT_INVOKE, 5'h00, 5'h00, 3'h3, 16'h00FF, 16'h2469);
      pop_data = 16'h1357;
      br(OP_POP_RETURN_TARGET, 5'h00, 5'h00, 3'h4, 16'h1357, 16'h2469);
      pop_data = 16'h0ABC;
      esr = esr | 8'h80;
      br(OP_INTERRUPT_EXIT, 5'h00, 5'h00, 3'h4, 16'h0ABC, 16'h2469);
      br(OP_COMPARE_SKIP_EQUAL, 5'h10, 5'h11, 3'h2, epc + 16'h0002, 16'h2469);
      br(OP_COMPARE_SKIP_EQUAL, 5'h10, ZPTR_LO, 3'h1, epc + 16'h0001, 16'h2469);
      next_two_word = 1'b1;
      br(OP_COMPARE_SKIP_EQUAL, 5'h10, 5'h11, 3'h3, epc + 16'h0003, 16'h2469);
      test_done;
   end
endmodule
